// >>> design/serial_port_defs.vh
// Constants for the asynchronous serial port: offsets, fields, reset values, timing
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Register offsets (word index on the plain register port)
`define REG_DATA      4'h0
`define REG_CTRL      4'h1
`define REG_BAUD_HI   4'h2
`define REG_BAUD_LO   4'h3
`define REG_BAUD_FRAC 4'h4
`define REG_STATUS    4'h5
`define REG_MASK      4'h6
`define REG_LEVEL     4'h7

// Control field positions
`define CTRL_EXT      0
`define CTRL_PAR_EN   1
`define CTRL_PAR_ODD  2
`define CTRL_NINE     3
`define CTRL_TWO_STOP 4
`define CTRL_FLOW     5
`define CTRL_TX_EN    6
`define CTRL_RX_EN    7

// Status and mask field positions
`define ST_RX_NE      0
`define ST_RX_HALF    1
`define ST_RX_FULL    2
`define ST_RX_OVF     3
`define ST_PAR_ERR    4
`define ST_FRM_ERR    5
`define ST_START_ERR  6
`define ST_TX_DONE    7

// Reset values
`define CTRL_RST      8'hC0
`define BAUD_HI_RST   8'h00
`define BAUD_LO_RST   8'h41
`define FRAC_RST      4'h0
`define MASK_RST      8'h00

// Timing: sixteen baud ticks per bit, sampled at tick index 7 and 15
`define OVERSAMPLE    16
`define TICK_LAST     4'hF
`define TICK_MID      4'h7

// Receive buffer depths
`define DEPTH_BASIC   5'h04
`define DEPTH_EXT     5'h10
`define PTR_MASK_BASIC 4'h3
`define PTR_MASK_EXT  4'hF

`endif

// >>> design/async_serial_port.v
// Asynchronous serial port: transmitter, receiver, receive buffer, baud generator, registers
//
// Contract
// - One start bit each frame, both directions
// - Basic mode: eight data bits per frame
// - Optional parity bit, odd or even
// - Basic mode: one stop bit, idle high
// - Least significant bit sent and received first
// - Four entry receive buffer, single transmit holding
// - Bit period from programmable divisor pair
// - Flags: nonempty, half, full, overflow, parity
// - Status pollable and able to interrupt
// - Start bit rechecked; glitches ignored
// - Divisor reaches 9600, 19200, 115200 baud
// - Extended mode: sixteen byte receive buffer
// - Extended mode: integer plus fractional divisor
// - Extended mode: nine bits, parity, stop count
// - Extended mode: CTS holds transmit, RTS drives
// - Extended mode: false start bit flagged
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defs.vh"

module async_serial_port (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Register port
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    // Serial link
    input wire rxd,
    output reg txd,
    input wire cts_n,
    output reg rts_n,
    // Interrupt
    output reg irq
);

    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_START = 5'b00010;
    localparam [4:0] S_DATA = 5'b00100;
    localparam [4:0] S_PAR = 5'b01000;
    localparam [4:0] S_STOP = 5'b10000;

    function par9;
        input [8:0] d;
        input nine;
        begin
            par9 = ^d[7:0] ^ (nine & d[8]);
        end
    endfunction

    reg [7:0] ctrl;
    reg [7:0] baud_hi;
    reg [7:0] baud_lo;
    reg [3:0] baud_frac;
    reg [7:0] mask;
    reg [7:0] status;

    wire ext = ctrl[`CTRL_EXT];
    wire nine = ext & ctrl[`CTRL_NINE];
    wire two_stop = ext & ctrl[`CTRL_TWO_STOP];
    wire flow = ext & ctrl[`CTRL_FLOW];
    wire par_en = ctrl[`CTRL_PAR_EN];
    wire par_odd = ctrl[`CTRL_PAR_ODD];
    wire [3:0] last_bit = nine ? 4'h8 : 4'h7;

    wire wr_data = wr & (addr == `REG_DATA);
    wire wr_ctrl = wr & (addr == `REG_CTRL);
    wire rd_data = rd & (addr == `REG_DATA);
    wire rd_status = rd & (addr == `REG_STATUS);

    // Baud tick: divisor pair plus fractional carry, sixteen ticks per bit
    reg [15:0] baud_cnt;
    reg [3:0] frac_acc;
    wire [15:0] divisor = {baud_hi, baud_lo};
    wire [15:0] div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor;
    wire [4:0] frac_sum = {1'b0, frac_acc} + {1'b0, (ext ? baud_frac : 4'h0)};
    wire tick = (baud_cnt == 16'h0000);

    always @(posedge mclk) begin
        if (sys_rst) begin
            baud_cnt <= 16'h0000;
            frac_acc <= 4'h0;
        end else if (tick) begin
            baud_cnt <= div_eff - 16'h0001 + {15'h0000, frac_sum[4]};
            frac_acc <= frac_sum[3:0];
        end else begin
            baud_cnt <= baud_cnt - 16'h0001;
        end
    end

    // Receive buffer
    reg [8:0] fifo_mem [0:15];
    reg [3:0] wr_ptr;
    reg [3:0] rd_ptr;
    reg [4:0] count;
    wire [4:0] depth = ext ? `DEPTH_EXT : `DEPTH_BASIC;
    wire [3:0] ptr_mask = ext ? `PTR_MASK_EXT : `PTR_MASK_BASIC;
    wire fifo_full = (count == depth);
    wire fifo_empty = (count == 5'h00);
    wire pop = rd_data & ~fifo_empty;

    // Receiver
    reg [4:0] rx_state;
    reg [3:0] rx_tick;
    reg [3:0] rx_bit;
    reg [8:0] rx_shift;
    reg rx_parbit;
    reg rx_push;
    reg [8:0] rx_word;
    reg ev_par;
    reg ev_frm;
    reg ev_start;
    wire [8:0] rx_aligned = nine ? rx_shift : {1'b0, rx_shift[8:1]};

    always @(posedge mclk) begin
        if (sys_rst) begin
            rx_state <= S_IDLE;
            rx_tick <= 4'h0;
            rx_bit <= 4'h0;
            rx_shift <= 9'h000;
            rx_parbit <= 1'b0;
            rx_push <= 1'b0;
            rx_word <= 9'h000;
            ev_par <= 1'b0;
            ev_frm <= 1'b0;
            ev_start <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            ev_par <= 1'b0;
            ev_frm <= 1'b0;
            ev_start <= 1'b0;
            case (rx_state)
                S_IDLE: begin
                    rx_tick <= 4'h0;
                    if (ctrl[`CTRL_RX_EN] & ~rxd) begin
                        rx_state <= S_START;
                    end
                end
                S_START: begin
                    if (tick) begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == `TICK_MID) begin
                            rx_tick <= 4'h0;
                            rx_bit <= 4'h0;
                            if (~rxd) begin
                                rx_state <= S_DATA;
                            end else begin
                                rx_state <= S_IDLE;
                                ev_start <= ext;
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (tick) begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == `TICK_LAST) begin
                            rx_shift <= {rxd, rx_shift[8:1]};
                            rx_bit <= rx_bit + 4'h1;
                            if (rx_bit == last_bit) begin
                                rx_state <= par_en ? S_PAR : S_STOP;
                            end
                        end
                    end
                end
                S_PAR: begin
                    if (tick) begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == `TICK_LAST) begin
                            rx_parbit <= rxd;
                            rx_state <= S_STOP;
                        end
                    end
                end
                S_STOP: begin
                    if (tick) begin
                        rx_tick <= rx_tick + 4'h1;
                        if (rx_tick == `TICK_LAST) begin
                            rx_state <= S_IDLE;
                            rx_push <= 1'b1;
                            rx_word <= rx_aligned;
                            ev_frm <= ~rxd;
                            ev_par <= par_en & (par9(rx_aligned, nine) ^ rx_parbit ^ par_odd);
                        end
                    end
                end
                default: begin
                    rx_state <= S_IDLE;
                end
            endcase
        end
    end

    wire push_ok = rx_push & ~fifo_full;
    wire ev_ovf = rx_push & fifo_full;

    always @(posedge mclk) begin
        if (push_ok) begin
            fifo_mem[wr_ptr] <= rx_word;
        end
    end

    always @(posedge mclk) begin
        if (sys_rst | wr_ctrl) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count <= 5'h00;
        end else begin
            if (push_ok) begin
                wr_ptr <= (wr_ptr + 4'h1) & ptr_mask;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr + 4'h1) & ptr_mask;
            end
            if (push_ok & ~pop) begin
                count <= count + 5'h01;
            end else if (pop & ~push_ok) begin
                count <= count - 5'h01;
            end
        end
    end

    // Transmitter with a single holding word
    reg [4:0] tx_state;
    reg [3:0] tx_tick;
    reg [3:0] tx_bit;
    reg [8:0] tx_shift;
    reg [8:0] tx_hold;
    reg tx_full;
    reg tx_par;
    reg tx_second;
    reg ev_txd;
    wire cts_ok = ~flow | ~cts_n;
    wire bit_end = tick & (tx_tick == `TICK_LAST);

    always @(posedge mclk) begin
        if (sys_rst) begin
            tx_state <= S_IDLE;
            tx_tick <= 4'h0;
            tx_bit <= 4'h0;
            tx_shift <= 9'h000;
            tx_hold <= 9'h000;
            tx_full <= 1'b0;
            tx_par <= 1'b0;
            tx_second <= 1'b0;
            ev_txd <= 1'b0;
            txd <= 1'b1;
        end else begin
            ev_txd <= 1'b0;
            if (wr_data & ~tx_full) begin
                tx_hold <= {nine & wdata[8], wdata[7:0]};
                tx_full <= 1'b1;
            end
            if (tick & (tx_state != S_IDLE)) begin
                tx_tick <= tx_tick + 4'h1;
            end
            case (tx_state)
                S_IDLE: begin
                    txd <= 1'b1;
                    tx_tick <= 4'h0;
                    if (tick & tx_full & ctrl[`CTRL_TX_EN] & cts_ok) begin
                        tx_state <= S_START;
                        tx_shift <= tx_hold;
                        tx_par <= par9(tx_hold, nine) ^ par_odd;
                        tx_full <= 1'b0;
                        txd <= 1'b0;
                    end
                end
                S_START: begin
                    if (bit_end) begin
                        tx_state <= S_DATA;
                        tx_bit <= 4'h0;
                        txd <= tx_shift[0];
                    end
                end
                S_DATA: begin
                    if (bit_end) begin
                        tx_shift <= {1'b0, tx_shift[8:1]};
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit == last_bit) begin
                            tx_state <= par_en ? S_PAR : S_STOP;
                            txd <= par_en ? tx_par : 1'b1;
                            tx_second <= 1'b0;
                        end else begin
                            txd <= tx_shift[1];
                        end
                    end
                end
                S_PAR: begin
                    if (bit_end) begin
                        tx_state <= S_STOP;
                        txd <= 1'b1;
                        tx_second <= 1'b0;
                    end
                end
                S_STOP: begin
                    txd <= 1'b1;
                    if (bit_end) begin
                        if (two_stop & ~tx_second) begin
                            tx_second <= 1'b1;
                        end else begin
                            tx_state <= S_IDLE;
                            ev_txd <= 1'b1;
                        end
                    end
                end
                default: begin
                    tx_state <= S_IDLE;
                end
            endcase
        end
    end

    // Sticky status: an event in the clearing cycle still sets its bit
    wire [7:0] ev_set;
    assign ev_set[`ST_RX_NE] = ~fifo_empty;
    assign ev_set[`ST_RX_HALF] = (count >= {1'b0, depth[4:1]});
    assign ev_set[`ST_RX_FULL] = fifo_full;
    assign ev_set[`ST_RX_OVF] = ev_ovf;
    assign ev_set[`ST_PAR_ERR] = ev_par;
    assign ev_set[`ST_FRM_ERR] = ev_frm;
    assign ev_set[`ST_START_ERR] = ev_start;
    assign ev_set[`ST_TX_DONE] = ev_txd;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_status
            always @(posedge mclk) begin
                if (sys_rst) begin
                    status[gi] <= 1'b0;
                end else begin
                    status[gi] <= ev_set[gi] | (status[gi] & ~rd_status);
                end
            end
        end
    endgenerate

    // Registers, read port, interrupt, flow output
    always @(posedge mclk) begin
        if (sys_rst) begin
            ctrl <= `CTRL_RST;
            baud_hi <= `BAUD_HI_RST;
            baud_lo <= `BAUD_LO_RST;
            baud_frac <= `FRAC_RST;
            mask <= `MASK_RST;
            rdata <= 16'h0000;
            irq <= 1'b0;
            rts_n <= 1'b1;
        end else begin
            if (wr) begin
                case (addr)
                    `REG_CTRL: ctrl <= wdata[7:0];
                    `REG_BAUD_HI: baud_hi <= wdata[7:0];
                    `REG_BAUD_LO: baud_lo <= wdata[7:0];
                    `REG_BAUD_FRAC: baud_frac <= wdata[3:0];
                    `REG_MASK: mask <= wdata[7:0];
                    default: begin
                    end
                endcase
            end
            rdata <= 16'h0000;
            if (rd) begin
                case (addr)
                    `REG_DATA: rdata <= fifo_empty ? 16'h0000 : {7'h00, fifo_mem[rd_ptr]};
                    `REG_CTRL: rdata <= {8'h00, ctrl};
                    `REG_BAUD_HI: rdata <= {8'h00, baud_hi};
                    `REG_BAUD_LO: rdata <= {8'h00, baud_lo};
                    `REG_BAUD_FRAC: rdata <= {12'h000, baud_frac};
                    `REG_STATUS: rdata <= {8'h00, status};
                    `REG_MASK: rdata <= {8'h00, mask};
                    `REG_LEVEL: rdata <= {9'h000, (tx_state != S_IDLE), tx_full, count};
                    default: rdata <= 16'h0000;
                endcase
            end
            irq <= |(status & mask);
            rts_n <= flow ? fifo_full : 1'b0;
        end
    end

endmodule // async_serial_port

`default_nettype wire

// >>> tb/async_serial_port_chk.sv
// Port assertions for the asynchronous serial port
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defs.vh"
module async_serial_port_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    // Serial side and interrupt
    input wire logic rxd,
    input wire logic txd,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic irq
);
    logic [7:0] ctrl_sh;
    logic [7:0] mask_sh;
    logic flow_on;
    // Shadows of what software wrote
    always @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_sh <= `CTRL_RST;
            mask_sh <= `MASK_RST;
        end else if (wr && addr == `REG_CTRL) begin
            ctrl_sh <= wdata[7:0];
        end else if (wr && addr == `REG_MASK) begin
            mask_sh <= wdata[7:0];
        end
    end
    assign flow_on = ctrl_sh[`CTRL_EXT] & ctrl_sh[`CTRL_FLOW];
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Even the fastest divisor keeps a line level for 16 cycles
    sequence low_bit;
        !txd [*8];
    endsequence
    sequence high_bit;
        txd [*8];
    endsequence
    chk_bit_low: assert property ($fell(txd) |-> low_bit)
        else $error("txd low level too short");
    chk_bit_high: assert property ($rose(txd) |-> high_bit)
        else $error("txd high level too short");
    chk_out_reset: assert property ($fell(sys_rst) |-> txd && rts_n && !irq)
        else $error("outputs not idle after reset");
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("rdata not zero outside read");
    chk_unmapped_zero: assert property (rd && addr > `REG_LEVEL |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_rts_flow: assert property (!flow_on ##1 !flow_on |-> !rts_n)
        else $error("rts_n high with flow off");
    chk_irq_masked: assert property (mask_sh == 8'h00 |=> !irq)
        else $error("irq with all sources masked");
    chk_ctrl_back: assert property (rd && addr == `REG_CTRL |=> rdata[7:0] == ctrl_sh)
        else $error("control readback wrong");
    chk_mask_back: assert property (rd && addr == `REG_MASK |=> rdata[7:0] == mask_sh)
        else $error("mask readback wrong");
endmodule // async_serial_port_chk

bind async_serial_port async_serial_port_chk u_async_serial_port_chk (
    .mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq)
);
`default_nettype wire

// >>> tb/serial_peer.sv
// Far-side serial device: frame sender and frame receiver
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    // Clock
    input wire logic mclk,
    // Serial lines
    input wire logic txd,
    output logic rxd,
    // Frame format
    input wire logic [15:0] bit_cyc,
    input wire logic par_en,
    input wire logic par_odd,
    input wire logic nine,
    // Received frame report
    output logic got,
    output logic [10:0] got_word
);
    initial begin
        rxd = 1'b1;
        got = 1'b0;
        got_word = 11'h000;
    end
    // Receiver samples each bit in its middle
    always begin : rx_side
        logic [10:0] w;
        int i;
        @(negedge txd);
        w = 11'h000;
        repeat (bit_cyc / 2) @(negedge mclk);
        if (txd === 1'b0) begin
            for (i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (bit_cyc) @(negedge mclk);
                w[i] = txd;
            end
            if (par_en) begin
                repeat (bit_cyc) @(negedge mclk);
                w[9] = txd;
            end
            repeat (bit_cyc) @(negedge mclk);
            w[10] = txd;
            got_word <= w;
            got <= 1'b1;
            @(negedge mclk);
            got <= 1'b0;
        end
    end
    task automatic drive_bit(input logic b);
        @(posedge mclk);
        rxd <= b;
        repeat (bit_cyc - 1) @(posedge mclk);
    endtask
    // Sends one frame, then one idle bit
    task automatic send_frame(input logic [8:0] d, input logic bad_par, input logic bad_stop);
        logic [8:0] v;
        int i;
        v = nine ? d : {1'b0, d[7:0]};
        drive_bit(1'b0);
        for (i = 0; i < (nine ? 9 : 8); i++) drive_bit(v[i]);
        if (par_en) drive_bit(^v ^ par_odd ^ bad_par);
        drive_bit(!bad_stop);
        drive_bit(1'b1);
    endtask
    task automatic glitch;
        @(posedge mclk);
        rxd <= 1'b0;
        repeat (3) @(posedge mclk);
        rxd <= 1'b1;
    endtask
endmodule // serial_peer
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    logic mclk, sys_rst, wr, rd, rd_d, cts_n, par_en, par_odd, nine, got;
    logic [3:0] addr;
    logic [15:0] wdata, bit_cyc;
    wire [15:0] rdata;
    wire rxd, txd, rts_n, irq;
    logic [10:0] got_word;
    int checked, mismatches, frames;
    logic [31:0] rq[$];
    logic [10:0] tq[$];
    async_serial_port u_async_serial_port (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
        .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
    serial_peer peer (.mclk(mclk), .txd(txd), .rxd(rxd), .bit_cyc(bit_cyc), .par_en(par_en),
        .par_odd(par_odd), .nine(nine), .got(got), .got_word(got_word));
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        addr <= a;
        rd <= 1'b1;
        rq.push_back({m, e & m});
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic [10:0] frame_of(input logic [8:0] d);
        logic [8:0] v;
        v = nine ? d : {1'b0, d[7:0]};
        return {1'b1, par_en & (^v ^ par_odd), v};
    endfunction
    task automatic wait_frame(input int n);
        repeat (20000) if (frames < n) @(posedge mclk);
        repeat (bit_cyc) @(posedge mclk);
    endtask
    task automatic send_tx(input logic [8:0] d);
        tq.push_back(frame_of(d));
        wr_reg(`REG_DATA, {7'h00, d});
        wait_frame(frames + 1);
    endtask
    // Watcher: each result is compared with the oldest note
    always @(posedge mclk) begin
        logic [31:0] e;
        logic [10:0] f;
        if (rd_d) begin
            e = rq.pop_front();
            `CHK(rdata & e[31:16], e[15:0])
        end
        if (got) begin
            frames++;
            f = tq.pop_front();
            `CHK(got_word, f)
        end
        rd_d <= rd;
    end
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        stop_test;
    end
    initial begin : main
        logic [8:0] b;
        logic [7:0] q[5];
        int m, k;
        {sys_rst, wr, rd, cts_n, par_en, par_odd, nine} = 7'h40;
        addr = 4'h0;
        wdata = 16'h0000;
        bit_cyc = 16'd1040;
        b = 9'($urandom(32'h82e5) & 32'h0);
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd_chk(`REG_CTRL, 16'h00C0, 16'h00FF);
        rd_chk(`REG_BAUD_LO, 16'h0041, 16'h00FF);
        rd_chk(`REG_STATUS, 16'h0000, 16'h00FF);
        rd_chk(4'hF, 16'h0000, 16'hFFFF);
        send_tx(9'(8'($urandom())));
        wr_reg(`REG_BAUD_LO, 16'h0001);
        bit_cyc <= 16'd16;
        for (m = 0; m < 3; m++) begin
            wr_reg(`REG_CTRL, m == 2 ? 16'h00C6 : (m == 1 ? 16'h00C2 : 16'h00C0));
            par_en = m != 0;
            par_odd = m == 2;
            b = 9'(8'($urandom()));
            send_tx(b);
            peer.send_frame(b, 1'b0, 1'b0);
            rd_chk(`REG_DATA, {7'h00, b}, 16'h01FF);
        end
        rd_chk(`REG_STATUS, 16'h0081, 16'h00FF);
        rd_chk(`REG_STATUS, 16'h0000, 16'h00FF);
        wr_reg(`REG_CTRL, 16'h00C0);
        par_en <= 1'b0;
        for (k = 0; k < 5; k++) begin
            q[k] = 8'($urandom());
            peer.send_frame({1'b0, q[k]}, 1'b0, 1'b0);
        end
        rd_chk(`REG_LEVEL, 16'h0004, 16'h001F);
        rd_chk(`REG_STATUS, 16'h000F, 16'h000F);
        for (k = 0; k < 4; k++) rd_chk(`REG_DATA, {8'h00, q[k]}, 16'h00FF);
        rd_chk(`REG_DATA, 16'h0000, 16'hFFFF);
        wr_reg(`REG_CTRL, 16'h00C2);
        par_en <= 1'b1;
        peer.send_frame(9'h05A, 1'b1, 1'b0);
        peer.send_frame(9'h0A5, 1'b0, 1'b1);
        rd_chk(`REG_STATUS, 16'h0030, 16'h0030);
        rd_chk(`REG_LEVEL, 16'h0002, 16'h001F);
        wr_reg(`REG_CTRL, 16'h00C0);
        par_en <= 1'b0;
        peer.glitch();
        repeat (200) @(posedge mclk);
        rd_chk(`REG_LEVEL, 16'h0000, 16'h001F);
        rd_chk(`REG_STATUS, 16'h0003, 16'h0003);
        wr_reg(`REG_MASK, 16'h0001);
        peer.send_frame(9'h03C, 1'b0, 1'b0);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b1)
        rd_chk(`REG_STATUS, 16'h0001, 16'h0001);
        rd_chk(`REG_DATA, 16'h003C, 16'h00FF);
        rd_chk(`REG_STATUS, 16'h0001, 16'h0001);
        rd_chk(`REG_STATUS, 16'h0000, 16'h0001);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        wr_reg(`REG_CTRL, 16'h00E1);
        cts_n <= 1'b1;
        k = frames;
        wr_reg(`REG_DATA, 16'h0033);
        repeat (300) @(posedge mclk);
        `CHK(frames, k)
        `CHK(rts_n, 1'b0)
        tq.push_back(frame_of(9'h033));
        cts_n <= 1'b0;
        wait_frame(k + 1);
        for (k = 0; k < 16; k++) peer.send_frame(9'(k), 1'b0, 1'b0);
        repeat (2) @(posedge mclk);
        `CHK(rts_n, 1'b1)
        rd_chk(`REG_LEVEL, 16'h0010, 16'h001F);
        peer.glitch();
        repeat (20) @(posedge mclk);
        rd_chk(`REG_STATUS, 16'h0040, 16'h0040);
        wr_reg(`REG_CTRL, 16'h00C9);
        nine <= 1'b1;
        @(posedge mclk);
        send_tx(9'h1A5);
        peer.send_frame(9'h15A, 1'b0, 1'b0);
        rd_chk(`REG_DATA, 16'h015A, 16'h01FF);
        repeat (4) @(posedge mclk);
        `CHK(tq.size(), 0)
        stop_test;
    end
endmodule // testbench
`default_nettype wire
